// ---- src/tsra_pkg.sv ----
// constants, codes and reset values for the temperature sensor control block
package tsra_pkg;

	////////////////////////////////////////////////////////////////////////
	// command codes (register offsets)
	localparam logic [7:0] CMD_LTEMP   = 8'h00;
	localparam logic [7:0] CMD_RTEMP   = 8'h01;
	localparam logic [7:0] CMD_STATUS  = 8'h02;
	localparam logic [7:0] CMD_CFG_RD  = 8'h03;
	localparam logic [7:0] CMD_RATE_RD = 8'h04;
	localparam logic [7:0] CMD_LHI_RD  = 8'h05;
	localparam logic [7:0] CMD_LLO_RD  = 8'h06;
	localparam logic [7:0] CMD_RHI_RD  = 8'h07;
	localparam logic [7:0] CMD_RLO_RD  = 8'h08;
	localparam logic [7:0] CMD_CFG_WR  = 8'h09;
	localparam logic [7:0] CMD_RATE_WR = 8'h0a;
	localparam logic [7:0] CMD_LHI_WR  = 8'h0b;
	localparam logic [7:0] CMD_LLO_WR  = 8'h0c;
	localparam logic [7:0] CMD_RHI_WR  = 8'h0d;
	localparam logic [7:0] CMD_RLO_WR  = 8'h0e;
	localparam logic [7:0] CMD_ONESHOT = 8'h0f;
	localparam logic [7:0] CMD_REXT    = 8'h10;
	localparam logic [7:0] CMD_OFFH    = 8'h11;
	localparam logic [7:0] CMD_OFFL    = 8'h12;
	localparam logic [7:0] CMD_ROT     = 8'h19;
	localparam logic [7:0] CMD_LOT     = 8'h20;
	localparam logic [7:0] CMD_OVERTEMP_HYSTERESIS    = 8'h21;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] PTR_RST  = 8'h00;
	localparam logic [7:0] CFG_RST  = 8'h20;
	localparam logic [7:0] RATE_RST = 8'h02;
	localparam logic [7:0] HI_RST   = 8'h7f;
	localparam logic [7:0] LO_RST   = 8'hc9;
	localparam logic [7:0] OT_RST   = 8'h7f;
	localparam logic [7:0] OVERTEMP_HYSTERESIS_RST = 8'h06;
	localparam logic [7:0] OFF_RST  = 8'h00;
	localparam logic [7:0] FLG_RST  = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int ST_BUSY   = 7;
	localparam int ST_OVI    = 1;
	localparam int ST_OVE    = 0;
	localparam int CFG_STOP  = 6;
	localparam int CFG_EXT   = 4;
	localparam int CFG_NOARA = 2;
	localparam int CFG_SRST  = 1;
	localparam logic [7:0] ST_CLR_MASK = 8'h7c;
	localparam logic [2:0] RATE_EXT_MAX = 3'h6;
	localparam logic [2:0] RATE_TOP     = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// slave addressing
	localparam logic [6:0] ARA_ADDR = 7'h0c;
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_HIZ = 2'h1;
	localparam logic [3:0] AHI_GND = 4'h3;
	localparam logic [3:0] AHI_HIZ = 4'h5;
	localparam logic [3:0] AHI_VCC = 4'h9;
	localparam logic [2:0] ALO_GND = 3'h0;
	localparam logic [2:0] ALO_HIZ = 3'h1;
	localparam logic [2:0] ALO_VCC = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_HZ  = 125_000_000;
	localparam int unsigned CONV_MS = 125;
	localparam int unsigned FAST_MS = 125;
	localparam int unsigned CONV_CYC_DEF = CLK_HZ / 1000 * CONV_MS;
	localparam int unsigned FAST_CYC_DEF = CLK_HZ / 1000 * FAST_MS;

	typedef enum logic [1:0] {S_IDLE, S_CONV, S_WAIT} tsra_conv_e;

endpackage : tsra_pkg

// ---- src/tsra_top.sv ----
// status, rate, offset and strapped address logic of the temperature sensor
`timescale 1ns/100ps
`default_nettype none
module tsra_top #(
	parameter int unsigned CONV_CYC = tsra_pkg::CONV_CYC_DEF,
	parameter int unsigned FAST_CYC = tsra_pkg::FAST_CYC_DEF
) (
	// core clock
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	// link side
	input  wire logic        link_clk_i,
	input  wire logic        link_req_i,
	input  wire logic        link_rd_i,
	input  wire logic        link_has_data_i,
	input  wire logic [6:0]  link_addr_i,
	input  wire logic [7:0]  link_cmd_i,
	input  wire logic [7:0]  link_wdata_i,
	output logic             link_busy_o,
	output logic             link_done_o,
	output logic             link_nak_o,
	output logic [7:0]       link_rdata_o,
	// analog front end and pins
	input  wire logic [7:0]  local_adc_i,
	input  wire logic [10:0] remote_adc_i,
	input  wire logic        open_diode_i,
	input  wire logic        standby_pin_i,
	input  wire logic        alert_cmp_mode_i,
	input  wire logic [1:0]  addr_strap_a_i,
	input  wire logic [1:0]  addr_strap_b_i,
	// status
	output logic [7:0]       alarm_flags_o,
	output logic [6:0]       slave_addr_o
);
	import tsra_pkg::*;

	function automatic logic [6:0] addr_dec(input logic [1:0] a,
		input logic [1:0] b);
		logic [3:0] hi;
		logic [2:0] lo;
		hi = (a == STRAP_GND) ? AHI_GND : (a == STRAP_HIZ) ? AHI_HIZ : AHI_VCC;
		lo = (a == STRAP_GND) ? ALO_GND : (a == STRAP_HIZ) ? ALO_HIZ : ALO_VCC;
		lo = lo + ((b == STRAP_GND) ? 3'h0 : (b == STRAP_HIZ) ? 3'h1 : 3'h2);
		return {hi, lo};
	endfunction : addr_dec

	function automatic logic ot_nxt(input logic cur, input logic [7:0] t,
		input logic [7:0] lim, input logic [7:0] hy);
		logic [8:0] lo;
		lo = {lim[7], lim} - {1'b0, hy};
		if ($signed(t) > $signed(lim))
			return 1'b1;
		if ($signed({t[7], t}) < $signed(lo))
			return 1'b0;
		return cur;
	endfunction : ot_nxt

	////////////////////////////////////////////////////////////////////////
	// link domain: hold request, toggle handshake
	logic       l_tgl_r, l_rd_r, l_hd_r;
	logic [6:0] l_addr_r;
	logic [7:0] l_cmd_r, l_wd_r;
	logic       ak_s1, ak_s2, ak_s3;
	logic       c_ack_r, c_nak_r;
	logic [7:0] c_rdata_r;

	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ak_s1 <= 1'b0;
			ak_s2 <= 1'b0;
			ak_s3 <= 1'b0;
		end else begin
			ak_s1 <= c_ack_r;
			ak_s2 <= ak_s1;
			ak_s3 <= ak_s2;
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			l_tgl_r <= 1'b0;
			l_rd_r <= 1'b0;
			l_hd_r <= 1'b0;
			l_addr_r <= 7'h00;
			l_cmd_r <= 8'h00;
			l_wd_r <= 8'h00;
			link_busy_o <= 1'b0;
			link_done_o <= 1'b0;
			link_nak_o <= 1'b0;
			link_rdata_o <= 8'h00;
		end else begin
			link_done_o <= 1'b0;
			if (link_req_i && !link_busy_o) begin
				l_tgl_r <= ~l_tgl_r;
				l_rd_r <= link_rd_i;
				l_hd_r <= link_has_data_i;
				l_addr_r <= link_addr_i;
				l_cmd_r <= link_cmd_i;
				l_wd_r <= link_wdata_i;
				link_busy_o <= 1'b1;
			end else if (ak_s2 ^ ak_s3) begin
				link_busy_o <= 1'b0;
				link_done_o <= 1'b1;
				link_nak_o <= c_nak_r;
				link_rdata_o <= c_rdata_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core synchronisers
	logic        rq_s1, rq_s2, rq_s3;
	logic [7:0]  la_s1, la_s2;
	logic [10:0] ra_s1, ra_s2;
	logic        op_s1, op_s2, sb_s1, sb_s2;
	logic [1:0]  sa_s1, sa_s2, sbb_s1, sbb_s2;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{rq_s1, rq_s2, rq_s3} <= 3'h0;
			{la_s1, la_s2} <= 16'h0000;
			{ra_s1, ra_s2} <= 22'h00_0000;
			{op_s1, op_s2, sb_s1, sb_s2} <= 4'h0;
			{sa_s1, sa_s2, sbb_s1, sbb_s2} <= 8'h00;
		end else if (ce_i) begin
			{rq_s1, rq_s2, rq_s3} <= {l_tgl_r, rq_s1, rq_s2};
			{la_s1, la_s2} <= {local_adc_i, la_s1};
			{ra_s1, ra_s2} <= {remote_adc_i, ra_s1};
			{op_s1, op_s2} <= {open_diode_i, op_s1};
			{sb_s1, sb_s2} <= {standby_pin_i, sb_s1};
			{sa_s1, sa_s2} <= {addr_strap_a_i, sa_s1};
			{sbb_s1, sbb_s2} <= {addr_strap_b_i, sbb_s1};
		end
	end

	wire req_ev = rq_s2 ^ rq_s3;

	////////////////////////////////////////////////////////////////////////
	// strap latch, after reset release and software reset
	logic [1:0] lat_cnt_r;
	logic       srst_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lat_cnt_r <= 2'h0;
			slave_addr_o <= 7'h00;
		end else if (ce_i) begin
			if (srst_r)
				lat_cnt_r <= 2'h0;
			else if (lat_cnt_r != 2'h3)
				lat_cnt_r <= lat_cnt_r + 2'h1;
			if (lat_cnt_r == 2'h2)
				slave_addr_o <= addr_dec(sa_s2, sbb_s2);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] ptr_r, cfg_r, rate_r, lhi_r, llo_r, rhi_r, rlo_r;
	logic [7:0] lot_r, rot_r, overtemp_hysteresis_r, offh_r, offl_r;
	logic [7:0] ltemp_r, flags_r, st_mask_r, cond_r;
	logic [10:0] rtemp_r;
	logic       st_clr_r, oneshot_r;

	wire match = (l_addr_r == slave_addr_o)
		|| (l_addr_r == ARA_ADDR && !cfg_r[CFG_NOARA]);
	wire wr_ev = req_ev && match && !l_rd_r && l_hd_r;

	function automatic logic [7:0] rd_mux(input logic [7:0] p);
		case (p)
			CMD_LTEMP:   return ltemp_r;
			CMD_RTEMP:   return rtemp_r[10:3];
			CMD_STATUS:  return flags_r;
			CMD_CFG_RD:  return cfg_r;
			CMD_RATE_RD: return rate_r;
			CMD_LHI_RD:  return lhi_r;
			CMD_LLO_RD:  return llo_r;
			CMD_RHI_RD:  return rhi_r;
			CMD_RLO_RD:  return rlo_r;
			CMD_REXT:    return {rtemp_r[2:0], 5'h00};
			CMD_OFFH:    return offh_r;
			CMD_OFFL:    return offl_r;
			CMD_ROT:     return rot_r;
			CMD_LOT:     return lot_r;
			CMD_OVERTEMP_HYSTERESIS:    return overtemp_hysteresis_r;
			default:     return 8'h00;
		endcase
	endfunction : rd_mux

	// transaction execution and answer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_r <= PTR_RST;
			c_ack_r <= 1'b0;
			c_nak_r <= 1'b0;
			c_rdata_r <= 8'h00;
			st_clr_r <= 1'b0;
			st_mask_r <= 8'h00;
			oneshot_r <= 1'b0;
			srst_r <= 1'b0;
		end else if (ce_i) begin
			st_clr_r <= 1'b0;
			oneshot_r <= 1'b0;
			srst_r <= 1'b0;
			if (srst_r) begin
				ptr_r <= PTR_RST;
			end else if (req_ev) begin
				c_ack_r <= ~c_ack_r;
				c_nak_r <= !match;
				c_rdata_r <= 8'h00;
				if (match && l_rd_r) begin
					if (l_addr_r == ARA_ADDR)
						c_rdata_r <= {slave_addr_o, 1'b0};
					else
						c_rdata_r <= rd_mux(ptr_r);
					if (l_addr_r != ARA_ADDR && ptr_r == CMD_STATUS) begin
						st_clr_r <= 1'b1;
						st_mask_r <= flags_r & ST_CLR_MASK;
					end
				end else if (match) begin
					ptr_r <= l_cmd_r;
					oneshot_r <= (l_cmd_r == CMD_ONESHOT);
					srst_r <= l_hd_r && l_cmd_r == CMD_CFG_WR
						&& l_wd_r[CFG_SRST];
				end
			end
		end
	end

	// writable registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_r <= CFG_RST;
			rate_r <= RATE_RST;
			{lhi_r, rhi_r, llo_r, rlo_r} <= {HI_RST, HI_RST, LO_RST, LO_RST};
			{lot_r, rot_r, overtemp_hysteresis_r} <= {OT_RST, OT_RST, OVERTEMP_HYSTERESIS_RST};
			{offh_r, offl_r} <= {OFF_RST, OFF_RST};
		end else if (ce_i) begin
			if (srst_r) begin
				cfg_r <= CFG_RST;
				rate_r <= RATE_RST;
				{lhi_r, rhi_r} <= {HI_RST, HI_RST};
				{llo_r, rlo_r} <= {LO_RST, LO_RST};
				{lot_r, rot_r} <= {OT_RST, OT_RST};
				overtemp_hysteresis_r <= OVERTEMP_HYSTERESIS_RST;
				{offh_r, offl_r} <= {OFF_RST, OFF_RST};
			end else if (wr_ev) begin
				case (l_cmd_r)
					CMD_CFG_WR:  cfg_r <= l_wd_r & 8'hfc;
					CMD_RATE_WR: rate_r <= l_wd_r;
					CMD_LHI_WR:  lhi_r <= l_wd_r;
					CMD_LLO_WR:  llo_r <= l_wd_r;
					CMD_RHI_WR:  rhi_r <= l_wd_r;
					CMD_RLO_WR:  rlo_r <= l_wd_r;
					CMD_OFFH:    offh_r <= l_wd_r;
					CMD_OFFL:    offl_r <= l_wd_r;
					CMD_ROT:     rot_r <= l_wd_r;
					CMD_LOT:     lot_r <= l_wd_r;
					CMD_OVERTEMP_HYSTERESIS:    overtemp_hysteresis_r <= l_wd_r;
					default:     ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion timing
	tsra_conv_e  st_r;
	logic [31:0] cnt_r;

	wire run = !cfg_r[CFG_STOP] && !sb_s2;
	wire [2:0] eff = (cfg_r[CFG_EXT] && rate_r[2:0] == RATE_TOP)
		? RATE_EXT_MAX : rate_r[2:0];
	wire [31:0] per = FAST_CYC << (RATE_TOP - eff);
	wire [31:0] gap = (per > CONV_CYC) ? per - CONV_CYC - 32'h1 : 32'h0;
	wire conv_end = (st_r == S_CONV) && (cnt_r == 32'h0) && run;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= S_IDLE;
			cnt_r <= 32'h0;
		end else if (ce_i) begin
			case (st_r)
				S_IDLE: begin
					if (!srst_r && (run || oneshot_r)) begin
						st_r <= S_CONV;
						cnt_r <= CONV_CYC - 32'h1;
					end
				end
				S_CONV: begin
					if (srst_r || !run)
						st_r <= S_IDLE;
					else if (cnt_r == 32'h0) begin
						st_r <= S_WAIT;
						cnt_r <= gap;
					end else
						cnt_r <= cnt_r - 32'h1;
				end
				S_WAIT: begin
					if (srst_r || !run)
						st_r <= S_IDLE;
					else if (oneshot_r || cnt_r == 32'h0) begin
						st_r <= S_CONV;
						cnt_r <= CONV_CYC - 32'h1;
					end else
						cnt_r <= cnt_r - 32'h1;
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// results at end of conversion
	wire [10:0] rsum = ra_s2 + {offh_r, offl_r[7:5]};
	wire [8:0] rint = {rsum[10], rsum[10:3]};
	wire [7:0] new_cond = {1'b0,
		$signed(la_s2) > $signed(lhi_r),
		$signed(la_s2) < $signed(llo_r),
		$signed(rint) > $signed({rhi_r[7], rhi_r}),
		$signed(rint) < $signed({rlo_r[7], rlo_r}),
		op_s2, 2'b00};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ltemp_r <= 8'h00;
			rtemp_r <= 11'h000;
			cond_r <= 8'h00;
		end else if (ce_i) begin
			if (srst_r)
				cond_r <= 8'h00;
			else if (conv_end) begin
				ltemp_r <= la_s2;
				rtemp_r <= rsum;
				cond_r <= new_cond;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags
	logic [7:0] flags_nxt;

	always_comb begin
		flags_nxt = flags_r;
		if (st_clr_r && !alert_cmp_mode_i)
			flags_nxt = flags_nxt & ~(st_mask_r & ~cond_r);
		if (conv_end) begin
			if (alert_cmp_mode_i)
				flags_nxt = (flags_nxt & ~ST_CLR_MASK) | new_cond;
			else
				flags_nxt = flags_nxt | new_cond;
		end
		flags_nxt[ST_BUSY] = (st_r == S_CONV);
		flags_nxt[ST_OVI] = ot_nxt(flags_r[ST_OVI], ltemp_r, lot_r, overtemp_hysteresis_r);
		flags_nxt[ST_OVE] = ot_nxt(flags_r[ST_OVE], rtemp_r[10:3],
			rot_r, overtemp_hysteresis_r);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			flags_r <= FLG_RST;
		else if (ce_i)
			flags_r <= srst_r ? FLG_RST : flags_nxt;
	end

	assign alarm_flags_o = flags_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_start;
		ce_i && st_r == S_IDLE && run && !srst_r;
	endsequence

	property p_busy;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_start ##1 ce_i && !srst_r |=> flags_r[ST_BUSY];
	endproperty
	a_busy: assert property (p_busy) else $error("busy not set");

	property p_rate_rst;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && srst_r |=> rate_r == 8'h02 && overtemp_hysteresis_r == 8'h06;
	endproperty
	a_rate_rst: assert property (p_rate_rst) else $error("reset value");

	property p_ext_cap;
		@(posedge clk_i) disable iff (!rst_n_i)
		cfg_r[CFG_EXT] |-> eff <= 3'h6 && per >= (FAST_CYC << 1);
	endproperty
	a_ext_cap: assert property (p_ext_cap) else $error("rate cap");

	property p_ovi;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !srst_r && $signed(ltemp_r) > $signed(lot_r) |=> flags_r[1];
	endproperty
	a_ovi: assert property (p_ovi) else $error("ovi missing");

	property p_ot_keep;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && st_clr_r && !srst_r && flags_r[ST_OVE]
			&& $signed(rtemp_r[10:3]) >= $signed(rot_r) |=> flags_r[0];
	endproperty
	a_ot_keep: assert property (p_ot_keep) else $error("ove lost");

	property p_rd_clr;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && st_clr_r && !srst_r && !alert_cmp_mode_i && !conv_end
			&& st_mask_r[6] && !cond_r[6] |=> !flags_r[6];
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("no clear");

	property p_addr;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && lat_cnt_r == 2'h2 && sa_s2 == 2'h2 && sbb_s2 == 2'h2
			|=> slave_addr_o == 7'h4e;
	endproperty
	a_addr: assert property (p_addr) else $error("addr decode");

	property p_offset;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && conv_end && !srst_r
			|=> rtemp_r == $past(ra_s2)
				+ $past({offh_r, offl_r[7:5]});
	endproperty
	a_offset: assert property (p_offset) else $error("offset sum");

	property p_stop;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && st_r == S_CONV && cfg_r[CFG_STOP] |=> st_r == S_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");

	property p_ptr;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && srst_r |=> ptr_r == 8'h00 ##1 1'b1;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer reset");

endmodule : tsra_top
`default_nettype wire

// ---- dv/tsra_host_model.sv ----
// host side model issuing register transfers on the link port
`timescale 1ns/100ps
`default_nettype none
module tsra_host_model (
	// link clock
	input  wire logic       link_clk_i,
	// answers
	input  wire logic       link_busy_i,
	input  wire logic       link_done_i,
	input  wire logic       link_nak_i,
	input  wire logic [7:0] link_rdata_i,
	// requests
	output logic            link_req_o,
	output logic            link_rd_o,
	output logic            link_has_data_o,
	output logic [6:0]      link_addr_o,
	output logic [7:0]      link_cmd_o,
	output logic [7:0]      link_wdata_o
);
	initial begin
		link_req_o = 1'b0;
		link_rd_o = 1'b0;
		link_has_data_o = 1'b0;
		link_addr_o = 7'h00;
		link_cmd_o = 8'h00;
		link_wdata_o = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic r, h, input logic [6:0] a,
		input logic [7:0] c, w, output logic [7:0] d,
		output logic k, output logic ok);
		int n;
		n = 0;
		@(posedge link_clk_i);
		#1;
		link_req_o = 1'b1;
		link_rd_o = r;
		link_has_data_o = h;
		link_addr_o = a;
		link_cmd_o = c;
		// data passed as given; t_rate sets the spare rate bits to ones
		link_wdata_o = w;
		do begin
			@(posedge link_clk_i);
			n++;
		end while (link_busy_i !== 1'b0 && n < 50);
		#1;
		// released lines never keep the stale value
		link_req_o = 1'b0;
		link_rd_o = ~r;
		link_has_data_o = ~h;
		link_addr_o = ~a;
		link_cmd_o = ~c;
		link_wdata_o = ~w;
		n = 0;
		do begin
			@(posedge link_clk_i);
			n++;
		end while (link_done_i !== 1'b1 && n < 60);
		d = link_rdata_i;
		k = link_nak_i;
		ok = (n < 60);
	endtask : xfer
endmodule : tsra_host_model
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the temperature sensor control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import tsra_pkg::*;
	localparam int CC = 20;
	localparam int FC = 40;
	logic        clk_i = 1'b0;
	logic        lclk = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        req, rd, hasd, busy, done, nak, opn = 1'b0;
	logic [6:0]  addr, sa, slave;
	logic [7:0]  cmd, wd, rdat, flags, ladc = 8'h19;
	logic [10:0] radc = 11'h0c0;
	logic [1:0]  sta = 2'h0, stb = 2'h1;
	logic        cmp = 1'b0, standby_pin = 1'b0;
	int          failures = 0, compares = 0;
	always #4 clk_i = ~clk_i;
	initial begin
		#37;
		forever #80 lclk = ~lclk;
	end
	tsra_top #(.CONV_CYC(CC), .FAST_CYC(FC)) dut (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .ce_i(1'b1), .link_clk_i(lclk),
		.link_req_i(req), .link_rd_i(rd), .link_has_data_i(hasd),
		.link_addr_i(addr), .link_cmd_i(cmd), .link_wdata_i(wd),
		.link_busy_o(busy), .link_done_o(done), .link_nak_o(nak),
		.link_rdata_o(rdat), .local_adc_i(ladc), .remote_adc_i(radc),
		.open_diode_i(opn), .standby_pin_i(standby_pin),
		.alert_cmp_mode_i(cmp), .addr_strap_a_i(sta),
		.addr_strap_b_i(stb), .alarm_flags_o(flags),
		.slave_addr_o(slave));
	tsra_host_model host (.link_clk_i(lclk), .link_busy_i(busy),
		.link_done_i(done), .link_nak_i(nak), .link_rdata_i(rdat),
		.link_req_o(req), .link_rd_o(rd), .link_has_data_o(hasd),
		.link_addr_o(addr), .link_cmd_o(cmd), .link_wdata_o(wd));
	////////////////////////////////////////////////////////////////////////
	task automatic chk8(input logic [7:0] g, e, input string m);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk8
	task automatic chkn(input int g, e, input string m);
		compares++;
		if (g != e) begin
			failures++;
			$display("Error %0t: %s got %0d exp %0d", $time, m, g, e);
		end
	endtask : chkn
	task automatic wrap_up;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	task automatic io(input logic r, h, input logic [6:0] a,
		input logic [7:0] c, w, output logic [7:0] d, output logic k);
		logic ok;
		host.xfer(r, h, a, c, w, d, k, ok);
		if (ok !== 1'b1) begin
			failures++;
			$display("Error %0t: no answer on link", $time);
		end
	endtask : io
	task automatic wr(input logic [7:0] c, w);
		logic [7:0] d;
		logic       k;
		io(1'b0, 1'b1, sa, c, w, d, k);
	endtask : wr
	task automatic rr(input logic [7:0] c, output logic [7:0] d);
		logic k;
		io(1'b0, 1'b0, sa, c, 8'h00, d, k);
		io(1'b1, 1'b0, sa, 8'h00, 8'h00, d, k);
	endtask : rr
	task automatic wb(input logic v, output int n);
		logic p;
		n = 0;
		p = flags[7];
		repeat (20000) begin
			@(posedge clk_i);
			#1;
			n++;
			if (p !== v && flags[7] === v)
				return;
			p = flags[7];
		end
		failures++;
		$display("Error %0t: no busy edge", $time);
	endtask : wb
	task automatic cv(input int k);
		int n;
		repeat (k) wb(1'b1, n);
	endtask : cv
	task automatic drv(input logic [7:0] l, input logic [10:0] r,
		input logic o);
		@(posedge clk_i);
		#1;
		ladc = l;
		radc = r;
		opn = o;
	endtask : drv
	function automatic logic [6:0] esa(input logic [1:0] a, b);
		logic [3:0] h;
		logic [2:0] l;
		h = (a == 2'h0) ? 4'h3 : (a == 2'h1) ? 4'h5 : 4'h9;
		l = (a == 2'h0) ? 3'h0 : (a == 2'h1) ? 3'h1 : 3'h4;
		return {h, l + ((b == 2'h3) ? 3'h2 : 3'(b))};
	endfunction : esa
	task automatic do_rst(input logic [1:0] a, b);
		sta = a;
		stb = b;
		rst_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		repeat (2) @(posedge lclk);
		@(posedge clk_i);
		#1 rst_n_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk8(flags, 8'h80, "busy after reset");
		repeat (3) @(posedge clk_i);
		#1;
		sa = esa(a, b);
		chk8({1'b0, slave}, {1'b0, sa}, "strap address");
	endtask : do_rst
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] d;
		logic       k;
		io(1'b1, 1'b0, sa, 8'h00, 8'h00, d, k);
		chk8(d, 8'h19, "pointer default");
		rr(CMD_RATE_RD, d);
		chk8(d, 8'h02, "rate default");
		rr(CMD_OVERTEMP_HYSTERESIS, d);
		chk8(d, 8'h06, "hysteresis");
		rr(CMD_LHI_RD, d);
		chk8(d, 8'h7f, "high limit");
		rr(CMD_RLO_RD, d);
		chk8(d, 8'hc9, "low limit");
		rr(CMD_CFG_RD, d);
		chk8(d, 8'h20, "sensor type");
		rr(CMD_OFFL, d);
		chk8(d, 8'h00, "offset low");
		wr(CMD_OFFH, 8'h05);
		rr(CMD_OFFH, d);
		chk8(d, 8'h05, "offset high");
		wr(CMD_OFFH, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic t_addr;
		logic [7:0] d;
		logic       k;
		for (int a = 0; a < 3; a++) begin
			for (int b = 0; b < 4; b++) begin
				do_rst(2'(a), 2'(b));
				sta = ~sta;
				stb = ~stb;
				repeat (20) @(posedge clk_i);
				#1;
				chk8({1'b0, slave}, {1'b0, sa}, "latched");
			end
		end
		do_rst(2'h0, 2'h1);
		io(1'b1, 1'b0, ARA_ADDR, 8'h00, 8'h00, d, k);
		chk8(d, {sa, 1'b0}, "alert response");
		io(1'b1, 1'b0, 7'h66, 8'h00, 8'h00, d, k);
		chk8({7'h00, k}, 8'h01, "foreign address");
		$display("address test done");
	endtask : t_addr
	task automatic t_rate;
		int n;
		for (int c = 0; c < 8; c++) begin
			wr(CMD_RATE_WR, 8'hf8 | 8'(c));
			repeat (3) wb(1'b1, n);
			chkn(n, FC << (7 - c), "period");
		end
		wb(1'b0, n);
		chkn(n, CC, "conversion time");
		wr(CMD_CFG_WR, 8'h30);
		repeat (3) wb(1'b1, n);
		chkn(n, FC << 1, "extended cap");
		wr(CMD_CFG_WR, 8'h20);
		$display("rate test done");
	endtask : t_rate
	task automatic t_alarm;
		logic [7:0] d;
		wr(CMD_LHI_WR, 8'h20);
		wr(CMD_RHI_WR, 8'h20);
		wr(CMD_LLO_WR, 8'h10);
		wr(CMD_RLO_WR, 8'h10);
		drv(8'h30, 11'h040, 1'b1);
		cv(3);
		chk8(flags & 8'h7c, 8'h4c, "alarms set");
		drv(8'h18, 11'h0c0, 1'b0);
		cv(2);
		chk8(flags & 8'h7c, 8'h4c, "alarms held");
		rr(CMD_STATUS, d);
		chk8(d & 8'h7c, 8'h4c, "status read");
		repeat (4) @(posedge clk_i);
		#1;
		chk8(flags & 8'h7c, 8'h00, "read cleared");
		drv(8'h08, 11'h180, 1'b0);
		cv(3);
		chk8(flags & 8'h7c, 8'h30, "alarms set");
		rr(CMD_STATUS, d);
		cv(1);
		chk8(flags & 8'h7c, 8'h30, "fault persists");
		drv(8'h18, 11'h0c0, 1'b0);
		cv(2);
		rr(CMD_STATUS, d);
		repeat (4) @(posedge clk_i);
		#1;
		chk8(flags & 8'h7c, 8'h00, "read cleared");
		wr(CMD_LHI_WR, 8'h7f);
		wr(CMD_RHI_WR, 8'h7f);
		wr(CMD_LOT, 8'h28);
		wr(CMD_ROT, 8'h28);
		drv(8'h30, 11'h180, 1'b0);
		cv(2);
		chk8(flags & 8'h03, 8'h03, "overtemp set");
		rr(CMD_STATUS, d);
		drv(8'h24, 11'h120, 1'b0);
		cv(2);
		chk8(flags & 8'h03, 8'h03, "hysteresis band");
		drv(8'h10, 11'h080, 1'b0);
		cv(2);
		chk8(flags & 8'h03, 8'h00, "overtemp gone");
		$display("alarm test done");
	endtask : t_alarm
	task automatic t_misc;
		logic [7:0] d;
		logic       k;
		int         n;
		wr(CMD_OFFH, 8'h02);
		cv(2);
		rr(CMD_RTEMP, d);
		chk8(d, 8'h12, "offset added");
		wr(CMD_OFFH, 8'h00);
		@(posedge clk_i);
		#1 cmp = 1'b1;
		wr(CMD_LHI_WR, 8'h20);
		drv(8'h30, 11'h080, 1'b0);
		cv(2);
		chk8(flags & 8'h7c, 8'h40, "comparator set");
		rr(CMD_STATUS, d);
		repeat (4) @(posedge clk_i);
		#1;
		chk8(flags & 8'h7c, 8'h40, "comparator read");
		drv(8'h18, 11'h080, 1'b0);
		cv(2);
		chk8(flags & 8'h7c, 8'h00, "comparator cleared");
		@(posedge clk_i);
		#1 cmp = 1'b0;
		wb(1'b1, n);
		standby_pin = 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
		chk8({7'h00, flags[7]}, 8'h00, "standby stops");
		standby_pin = 1'b0;
		wr(CMD_RATE_WR, 8'h00);
		repeat (2) wb(1'b1, n);
		repeat (CC + 4) @(posedge clk_i);
		drv(8'h22, 11'h080, 1'b0);
		io(1'b0, 1'b0, sa, CMD_ONESHOT, 8'h00, d, k);
		rr(CMD_LTEMP, d);
		chk8(d, 8'h22, "one-shot result");
		sta = 2'h2;
		stb = 2'h2;
		wr(CMD_CFG_WR, 8'h22);
		repeat (8) @(posedge clk_i);
		#1;
		chk8({1'b0, slave}, 8'h4e, "soft reset straps");
		sa = esa(2'h2, 2'h2);
		rr(CMD_RATE_RD, d);
		chk8(d, 8'h02, "soft reset rate");
		$display("misc test done");
	endtask : t_misc
	task automatic t_stop;
		int n;
		wr(CMD_CFG_WR, 8'h60);
		chk8({7'h00, flags[7]}, 8'h00, "stopped");
		repeat (300) @(posedge clk_i);
		#1;
		chk8({7'h00, flags[7]}, 8'h00, "stays stopped");
		wr(CMD_CFG_WR, 8'h20);
		wb(1'b1, n);
		chk8({7'h00, flags[7]}, 8'h01, "runs again");
		$display("stop test done");
	endtask : t_stop
	////////////////////////////////////////////////////////////////////////
	initial begin
		do_rst(2'h0, 2'h1);
		t_reset();
		t_addr();
		t_rate();
		t_alarm();
		t_misc();
		t_stop();
		wrap_up();
	end
	initial begin
		#800_000;
		failures++;
		$display("Error %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
